// file: hdl/fpro_norm.v
/*
  Normaliser for one working mantissa: shifts left until the bit below
  the sign differs from the sign, and reports the shift count.
  Assumes a two's-complement fraction with the sign in the top bit.
*/
`default_nettype none
`timescale 1ns/1ps

module fpro_norm #(
  parameter W  = 31,
  parameter CW = 5
) (
  // preliminary working mantissa
  input  wire [W-1:0]  raw,
  // normalised mantissa and shift count
  output reg  [W-1:0]  norm,
  output reg  [CW-1:0] count
);

  integer k;
  reg     done;

  // leading sign run; an all-zero input shifts fully out to zero
  always @* begin
    done  = 1'b0;
    count = {CW{1'b0}};
    for (k = W - 2; k >= 0; k = k - 1) begin
      if (!done) begin
        if (raw[k] != raw[W-1]) begin
          done = 1'b1;
        end else begin
          count = count + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
    norm = raw << count;
  end

endmodule // fpro_norm

`default_nettype wire

// file: hdl/fpro_post.v
/*
  Post-processing of the floating adder and floating multiplier
  preliminary results: sticky residue, normalisation, half-toward-zero
  rounding or truncation, rounding overflow repair, and exponent
  overflow / underflow clamping with sticky status flags.
  Assumes the instruction control unit presents each preliminary
  result for one cycle with its valid strobe, with a mantissa that has
  not overflowed before rounding, and a 12-bit signed apparent
  exponent.
*/
`default_nettype none
`timescale 1ns/1ps
`include "fpro_map.vh"

module fpro_post (
  // clock and reset
  input  wire                        clock,
  input  wire                        arst_n,
  // floating adder preliminary result
  input  wire                        add_valid,
  input  wire                        add_truncate,
  input  wire [`FPRO_PEXP_W-1:0]     add_exp,
  input  wire [`FPRO_ADD_W-1:0]      add_mant,
  // floating multiplier preliminary result
  input  wire                        mul_valid,
  input  wire [`FPRO_PEXP_W-1:0]     mul_exp,
  input  wire [`FPRO_MUL_W-1:0]      mul_mant,
  // processor status register clear of both flags
  input  wire                        status_clear,
  // final adder result
  output reg                         adder_result_valid,
  output reg  [`FPRO_EXP_W-1:0]      adder_result_exp,
  output reg  [`FPRO_MANT_W-1:0]     adder_result_mant,
  // final multiplier result
  output reg                         multiplier_result_valid,
  output reg  [`FPRO_EXP_W-1:0]      multiplier_result_exp,
  output reg  [`FPRO_MANT_W-1:0]     multiplier_result_mant,
  // processor status register flags
  output reg                         overflow_flag,
  output reg                         underflow_flag
);

  // *********************************************************************
  // unit lanes: index 0 is the adder, index 1 the multiplier
  // *********************************************************************

  // multiplier mantissa padded below so both lanes share one layout
  wire [2*`FPRO_ADD_W-1:0] raw_all;
  wire [1:0]               valid_all;
  wire [1:0]               trunc_all;
  wire [2*`FPRO_PEXP_W-1:0] pexp_all;

  assign raw_all   = {mul_mant, `FPRO_MUL_PAD, add_mant};
  assign valid_all = {mul_valid, add_valid};
  assign trunc_all = {1'b0, add_truncate};  // only the adder truncates
  assign pexp_all  = {mul_exp, add_exp};

  // per-lane final values, flat
  wire [2*`FPRO_EXP_W-1:0]  fin_exp;
  wire [2*`FPRO_MANT_W-1:0] fin_mant;
  wire [1:0]                fin_ovf;
  wire [1:0]                fin_unf;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_lane

      // *****************************************************************
      // sticky residue and normalisation
      // *****************************************************************
      wire [`FPRO_ADD_W-1:0]  raw;
      wire [`FPRO_WORK_W-1:0] work;
      wire [`FPRO_WORK_W-1:0] norm;
      wire [`FPRO_CNT_W-1:0]  cnt;

      assign raw = raw_all[i*`FPRO_ADD_W +: `FPRO_ADD_W];

      // bits below guard 30 collapse into it before any shift
      assign work = {raw[`FPRO_RAW_TOP:`FPRO_RAW_G30+1],
                     raw[`FPRO_RAW_G30] |
                     (|raw[`FPRO_RAW_STKH:0])};

      // shift happens ahead of the rounding decision
      fpro_norm #(
        .W  (`FPRO_WORK_W),
        .CW (`FPRO_CNT_W)
      ) u_norm (
        .raw   (work),
        .norm  (norm),
        .count (cnt)
      );

      // *****************************************************************
      // rounding or truncation decision
      // *****************************************************************
      wire [`FPRO_MANT_W-1:0]  q;
      wire [`FPRO_GUARD_W-1:0] g;
      wire                     sgn;
      wire                     inc_rnd;
      wire                     inc_trn;
      wire                     inc;

      assign q   = norm[`FPRO_WORK_W-1:`FPRO_GUARD_W];
      assign g   = norm[`FPRO_GUARD_W-1:0];
      assign sgn = q[`FPRO_MANT_W-1];

      // exactly half an LSB rounds down on the positive side, which is
      // what skews the distribution toward zero
      assign inc_rnd = sgn ? g[`FPRO_GUARD_W-1]
                           : (g > `FPRO_HALF_LSB);
      // truncation toward zero: negatives with any residue step up
      assign inc_trn = sgn & (g != `FPRO_GUARD_0);
      assign inc     = trunc_all[i] ? inc_trn : inc_rnd;

      // *****************************************************************
      // rounding add and mantissa overflow repair
      // *****************************************************************
      wire [`FPRO_MANT_W:0]   sum;
      wire                    movf;
      wire [`FPRO_MANT_W-1:0] rmant;

      assign sum  = {sgn, q} + {{`FPRO_MANT_W{1'b0}}, inc};
      assign movf = sum[`FPRO_MANT_W] ^ sum[`FPRO_MANT_W-1];
      // a carry into the sign moves right one place
      assign rmant = movf ? sum[`FPRO_MANT_W:1]
                          : sum[`FPRO_MANT_W-1:0];

      // *****************************************************************
      // exponent after normalisation and repair
      // *****************************************************************
      wire [`FPRO_WEXP_W-1:0] pexp;
      wire [`FPRO_WEXP_W-1:0] eadj;
      wire                    zero_in;
      wire                    ovf;
      wire                    unf;

      // one extra bit keeps the normalising subtraction from wrapping
      assign pexp = {pexp_all[(i+1)*`FPRO_PEXP_W-1],
                     pexp_all[i*`FPRO_PEXP_W +: `FPRO_PEXP_W]};
      assign eadj = pexp
                  - {{(`FPRO_WEXP_W-`FPRO_CNT_W){1'b0}}, cnt}
                  + {{(`FPRO_WEXP_W-1){1'b0}}, movf};

      // a zero mantissa is exact zero and raises nothing
      assign zero_in = (work == {`FPRO_WORK_W{1'b0}});

      // checks use the final exponent of this lane only
      assign ovf = ~zero_in &
                   ($signed(eadj) > $signed(`FPRO_EXP_MAX));
      assign unf = ~zero_in & eadj[`FPRO_WEXP_W-1];

      // *****************************************************************
      // forced values
      // *****************************************************************
      reg [`FPRO_EXP_W-1:0]  fe;
      reg [`FPRO_MANT_W-1:0] fm;

      always @* begin
        if (ovf) begin
          fe = `FPRO_MAXE;
          fm = rmant[`FPRO_MANT_W-1] ? `FPRO_MAXN_M
                                     : `FPRO_MAXP_M;
        end else if (unf || zero_in) begin
          fe = `FPRO_ZERO_E;
          fm = `FPRO_ZERO_M;
        end else begin
          fe = eadj[`FPRO_EXP_W-1:0];
          fm = rmant;
        end
      end

      // each lane only forces its own word
      assign fin_exp[i*`FPRO_EXP_W +: `FPRO_EXP_W]    = fe;
      assign fin_mant[i*`FPRO_MANT_W +: `FPRO_MANT_W] = fm;
      assign fin_ovf[i] = ovf & valid_all[i];
      assign fin_unf[i] = unf & valid_all[i];
    end
  endgenerate

  // *********************************************************************
  // result registers
  // *********************************************************************

  // one cycle from preliminary strobe to final result
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      adder_result_valid      <= 1'b0;
      adder_result_exp        <= `FPRO_ZERO_E;
      adder_result_mant       <= `FPRO_ZERO_M;
      multiplier_result_valid <= 1'b0;
      multiplier_result_exp   <= `FPRO_ZERO_E;
      multiplier_result_mant  <= `FPRO_ZERO_M;
    end else begin
      adder_result_valid      <= add_valid;
      multiplier_result_valid <= mul_valid;
      // results hold between strobes so the consumer may sample late
      if (add_valid) begin
        adder_result_exp  <= fin_exp[`FPRO_EXP_W-1:0];
        adder_result_mant <= fin_mant[`FPRO_MANT_W-1:0];
      end
      if (mul_valid) begin
        multiplier_result_exp  <= fin_exp[2*`FPRO_EXP_W-1:`FPRO_EXP_W];
        multiplier_result_mant <= fin_mant[2*`FPRO_MANT_W-1:`FPRO_MANT_W];
      end
    end
  end

  // *********************************************************************
  // status flags
  // *********************************************************************

  // sticky; a new event in the clear cycle wins so none is lost
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      overflow_flag  <= 1'b0;
      underflow_flag <= 1'b0;
    end else begin
      overflow_flag  <= (|fin_ovf) |
                        (overflow_flag & ~status_clear);
      underflow_flag <= (|fin_unf) |
                        (underflow_flag & ~status_clear);
    end
  end

endmodule // fpro_post

`default_nettype wire

// file: pkg/fpro_map.vh
/*
  Constants of the floating result post-processing stage: word layout,
  working widths, guard pattern thresholds and forced result values.
  Assumes inclusion by bare name from the design files only.
*/
`ifndef FPRO_MAP_VH
`define FPRO_MAP_VH

// ***********************************************************************
// word layout
// ***********************************************************************
`define FPRO_EXP_W     10
`define FPRO_MANT_W    28
`define FPRO_GUARD_W   3
`define FPRO_WORK_W    31
`define FPRO_CNT_W     5
`define FPRO_ADD_W     59
`define FPRO_MUL_W     51
`define FPRO_MUL_PAD   8'h00
`define FPRO_PEXP_W    12
`define FPRO_WEXP_W    13

// ***********************************************************************
// field positions inside the widened raw mantissa, sign at the top
// ***********************************************************************
`define FPRO_RAW_TOP   58
`define FPRO_RAW_G30   28
`define FPRO_RAW_STKH  27

// ***********************************************************************
// rounding thresholds and exponent limits (apparent values)
// ***********************************************************************
`define FPRO_HALF_LSB  3'h4
`define FPRO_GUARD_0   3'h0
`define FPRO_EXP_MAX   13'h03ff
`define FPRO_EXP_BIAS  10'h200

// ***********************************************************************
// forced results
// ***********************************************************************
`define FPRO_MAXE      10'h3ff
`define FPRO_MAXP_M    28'h7ffffff
`define FPRO_MAXN_M    28'h8000000
`define FPRO_ZERO_E    10'h000
`define FPRO_ZERO_M    28'h0000000

`endif

// file: tb/fpro_icu.sv
/* instruction control unit model: issues preliminary results.
   assumes the bench calls issue from one thread at a time. */
`timescale 1ns/1ps
`default_nettype none
module fpro_icu (
  // clock
  input  wire logic        clock,
  // adder request
  output var  logic        add_valid,
  output var  logic        add_truncate,
  output var  logic [11:0] add_exp,
  output var  logic [58:0] add_mant,
  // multiplier request
  output var  logic        mul_valid,
  output var  logic [11:0] mul_exp,
  output var  logic [50:0] mul_mant
);
  // ****************
  // request driver
  // ****************
  initial begin
    {add_valid, add_truncate, add_exp, add_mant} = '0;
    {mul_valid, mul_exp, mul_mant} = '0;
  end
  // one strobe per call; mantissas are inverted afterwards so that a
  // stale word can never pass for a live one
  task automatic issue(input logic av, input logic [11:0] ae,
    input logic [58:0] am, input logic at, input logic mv,
    input logic [11:0] me, input logic [50:0] mm);
    @(posedge clock);
    {add_valid, add_exp, add_mant, add_truncate} <= {av, ae, am, at};
    {mul_valid, mul_exp, mul_mant} <= {mv, me, mm};
    @(posedge clock);
    {add_valid, mul_valid} <= 2'h0;
    {add_mant, mul_mant} <= {~am, ~mm};
  endtask
endmodule // fpro_icu
`default_nettype wire

// file: tb/fpro_post_assertions.sv
/* port checker of fpro_post: result timing, flags, forced words.
   assumes a bind onto fpro_post and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module fpro_post_chk (
  // clock and reset
  input wire logic        clock,
  input wire logic        arst_n,
  // requests
  input wire logic        add_valid,
  input wire logic        mul_valid,
  input wire logic        status_clear,
  // results and flags
  input wire logic        adder_result_valid,
  input wire logic [9:0]  adder_result_exp,
  input wire logic [27:0] adder_result_mant,
  input wire logic        multiplier_result_valid,
  input wire logic        overflow_flag,
  input wire logic        underflow_flag
);
  // ****************
  // port relations
  // ****************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  add_lat_a: assert property (add_valid |=> adder_result_valid)
    else $error("adder result late");
  add_quiet_a: assert property (!add_valid |=> !adder_result_valid
    && $stable(adder_result_mant)) else $error("adder word moved");
  mul_lat_a: assert property (1'b1 |=> multiplier_result_valid
    == $past(mul_valid)) else $error("multiplier strobe wrong");
  // positive adder words leave normalised; zero and -0.5 forms excluded
  norm_out_a: assert property (adder_result_valid
    && !adder_result_mant[27] && |adder_result_mant
    |-> adder_result_mant[26]) else $error("unnormalised word");
  ovf_cause_a: assert property ($rose(overflow_flag)
    |-> adder_result_valid || multiplier_result_valid)
    else $error("overflow without result");
  ovf_word_a: assert property ($rose(overflow_flag)
    && !multiplier_result_valid |-> adder_result_exp == 10'h3ff
    && (adder_result_mant == 28'h7ffffff
    || adder_result_mant == 28'h8000000)) else $error("bad max word");
  unf_word_a: assert property ($rose(underflow_flag)
    && !multiplier_result_valid |-> adder_result_exp == 10'h000
    && adder_result_mant == 28'h0) else $error("bad zero word");
  flag_hold_a: assert property (overflow_flag && !status_clear
    |=> overflow_flag) else $error("overflow flag lost");
  flag_clr_a: assert property (status_clear && !add_valid
    && !mul_valid |=> !overflow_flag && !underflow_flag)
    else $error("flags not cleared");
endmodule // fpro_post_chk
bind fpro_post fpro_post_chk chk (.clock, .arst_n, .add_valid,
  .mul_valid, .status_clear, .adder_result_valid, .adder_result_exp,
  .adder_result_mant, .multiplier_result_valid, .overflow_flag,
  .underflow_flag);
`default_nettype wire

// file: tb/fpro_post_tb_top.sv
/* self-checking bench of fpro_post, stimulus through fpro_icu.
   assumes fixed one-cycle result latency. */
`timescale 1ns/1ps
`default_nettype none
module fpro_post_tb_top;
  logic        clock, arst_n, status_clear;
  logic        add_valid, add_truncate, mul_valid;
  logic [11:0] add_exp, mul_exp;
  logic [58:0] add_mant;
  logic [50:0] mul_mant;
  logic        adder_result_valid, multiplier_result_valid;
  logic [9:0]  adder_result_exp, multiplier_result_exp;
  logic [27:0] adder_result_mant, multiplier_result_mant;
  logic        overflow_flag, underflow_flag;
  int          fails, check_count;
  fpro_post uut (.clock, .arst_n, .add_valid, .add_truncate, .add_exp,
    .add_mant, .mul_valid, .mul_exp, .mul_mant, .status_clear,
    .adder_result_valid, .adder_result_exp, .adder_result_mant,
    .multiplier_result_valid, .multiplier_result_exp,
    .multiplier_result_mant, .overflow_flag, .underflow_flag);
  fpro_icu icu (.clock, .add_valid, .add_truncate, .add_exp,
    .add_mant, .mul_valid, .mul_exp, .mul_mant);
  // ****************
  // helpers
  // ****************
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // words are {mantissa, guard, low residue}; answer one edge later
  task automatic tadd(input logic [11:0] e, input logic [27:0] m,
    input logic [2:0] g, input logic [27:0] lo, input logic t,
    input logic [9:0] we, input logic [27:0] wm);
    icu.issue(1'b1, e, {m, g, lo}, t, 1'b0, 12'h000, 51'h0);
    #1;
    check({adder_result_valid, adder_result_exp, adder_result_mant},
      {1'b1, we, wm});
  endtask
  task automatic tmul(input logic [11:0] e, input logic [27:0] m,
    input logic [2:0] g, input logic [19:0] lo,
    input logic [9:0] we, input logic [27:0] wm);
    icu.issue(1'b0, 12'h000, 59'h0, 1'b0, 1'b1, e, {m, g, lo});
    #1;
    check({multiplier_result_valid, multiplier_result_exp,
      multiplier_result_mant}, {1'b1, we, wm});
  endtask
  // clear pulse then flag check
  task automatic clr;
    @(posedge clock);
    status_clear <= 1'b1;
    @(posedge clock);
    status_clear <= 1'b0;
    #1;
    check({overflow_flag, underflow_flag}, 2'h0);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_round;
    for (int g = 0; g < 8; g++) begin
      tadd(12'h100, 28'h4000000, g[2:0], 28'h0, 1'b0, 10'h100,
        28'h4000000 + 28'(g > 4));
      tadd(12'h100, 28'hb000000, g[2:0], 28'h0, 1'b0, 10'h100,
        28'hb000000 + 28'(g > 3));
    end
    $display("t_round done");
  endtask
  task automatic t_sticky;
    tadd(12'h100, 28'h4000000, 3'h4, 28'h1, 0, 10'h100, 28'h4000001);
    tmul(12'h100, 28'h4000000, 3'h4, 20'h1, 10'h100, 28'h4000001);
    tadd(12'h100, 28'hb000000, 3'h0, 28'h8000000, 1, 10'h100,
      28'hb000001);
    tadd(12'h100, 28'h4000000, 3'h7, 28'hfffffff, 1, 10'h100,
      28'h4000000);
    // negative with no residue at all must stay untouched
    tadd(12'h100, 28'hb000000, 3'h0, 28'h0, 1, 10'h100, 28'hb000000);
    $display("t_sticky done");
  endtask
  task automatic t_norm;
    tadd(12'h100, 28'h2000000, 3'h3, 28'h0, 0, 10'h0ff, 28'h4000001);
    tmul(12'h100, 28'h2000000, 3'h3, 20'h0, 10'h0ff, 28'h4000001);
    tadd(12'h100, 28'he800000, 3'h0, 28'h0, 0, 10'h0fe, 28'ha000000);
    $display("t_norm done");
  endtask
  task automatic t_range;
    tadd(12'h100, 28'h7ffffff, 3'h7, 28'h0, 0, 10'h101, 28'h4000000);
    tadd(12'h3ff, 28'h7ffffff, 3'h7, 28'h0, 0, 10'h3ff, 28'h7ffffff);
    check({overflow_flag, underflow_flag}, 2'h2);
    clr();
    tadd(12'h400, 28'hb000000, 3'h0, 28'h0, 0, 10'h3ff, 28'h8000000);
    tadd(12'hfff, 28'h4000000, 3'h0, 28'h0, 0, 10'h000, 28'h0);
    check({overflow_flag, underflow_flag}, 2'h3);
    clr();
    tadd(12'h000, 28'h2000000, 3'h0, 28'h0, 0, 10'h000, 28'h0);
    check(underflow_flag, 1'b1);
    clr();
    // multiplier lane forces its own word in both directions
    tmul(12'h7ff, 28'hb000000, 3'h0, 20'h0, 10'h3ff, 28'h8000000);
    tmul(12'h800, 28'h4000000, 3'h0, 20'h0, 10'h000, 28'h0);
    check({overflow_flag, underflow_flag}, 2'h3);
    clr();
    // an exact zero mantissa gives the zero word and raises nothing
    tadd(12'h100, 28'h0, 3'h0, 28'h0, 0, 10'h000, 28'h0);
    check({overflow_flag, underflow_flag}, 2'h0);
    $display("t_range done");
  endtask
  // adder overflows while the multiplier stays in range; the clear
  // is held over the request edge, where the new event must win
  task automatic t_units;
    @(posedge clock);
    status_clear <= 1'b1;
    icu.issue(1'b1, 12'h500, {28'h4000000, 31'h0}, 1'b0, 1'b1,
      12'h100, {28'h4000000, 23'h0});
    #1;
    check({adder_result_exp, adder_result_mant}, 38'h3ff7ffffff);
    check({multiplier_result_exp, multiplier_result_mant},
      38'h1004000000);
    check(overflow_flag, 1'b1);
    @(posedge clock);
    status_clear <= 1'b0;
    $display("t_units done");
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    arst_n = 1'b0;
    status_clear = 1'b0;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    t_round();
    t_sticky();
    t_norm();
    t_range();
    t_units();
    end_sim();
  end
  // hang guard: runs out only if the sequence stalls
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    end_sim();
  end
endmodule // fpro_post_tb_top
`default_nettype wire
